// ===== core/lpc_ctl_pkg.sv
// Overview of operation
// R1 - Any channel enabled makes link take part
// R2 - Channel enables at bits 7,6,5, reset 0
// R3 - Channel 3 disabled: no programmed-address matches
// R4 - Channel 2 disabled: 62h/66h never decoded
// R5 - Channel 1 disabled: 60h/64h never decoded
// R6 - Fast gate off: pin released, gate forced 1
// R7 - Fast gate on: open-drain, pulls low only
// R8 - Shutdown enable plus low power-down: shutdown
// R9 - Shutdown enable sets only after reading 0
// R10 - Shutdown enable cleared by 0, resets, release
// R11 - Power-down input stops host transfer participation
// R12 - Fast gate handled on channel 1 only
// R13 - Control register unreachable from host cycles
package lpc_ctl_pkg;

	// ----------------------------------------------------------------
	// Register map and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTL0 = 8'h00;
	localparam logic [7:0] ADDR_LINK = 8'h01;
	localparam logic [7:0] ADDR_CH3_HI = 8'h02;
	localparam logic [7:0] ADDR_CH3_LO = 8'h03;
	localparam int BIT_CH3 = 7;
	localparam int BIT_CH2 = 6;
	localparam int BIT_CH1 = 5;
	localparam int BIT_FGATE = 4;
	localparam int BIT_SDWN = 3;
	localparam logic [7:0] CTL0_RESET = 8'h00;
	localparam int LBIT_SOFTRST = 0;
	localparam int LBIT_LRST = 1;
	localparam int LBIT_PDLOW = 2;
	localparam int LBIT_HWSHUT = 3;
	localparam int LBIT_BUSY = 4;
	localparam logic [15:0] CH3_ADDR_RESET = 16'h0000;

	// ----------------------------------------------------------------
	// Link codes and host addresses
	// ----------------------------------------------------------------
	localparam logic [3:0] LAD_START = 4'h0;
	localparam logic [3:0] CT_IORD = 4'h0;
	localparam logic [3:0] CT_IOWR = 4'h2;
	localparam logic [3:0] LAD_SYNC_READY = 4'h0;
	localparam logic [3:0] LAD_TAR = 4'hf;
	localparam logic [1:0] NIB_LAST_ADDR = 2'h3;
	localparam logic [1:0] NIB_LAST_BYTE = 2'h1;
	localparam logic [15:0] CH1_DATA = 16'h0060;
	localparam logic [15:0] CH1_CMD = 16'h0064;
	localparam logic [15:0] CH2_DATA = 16'h0062;
	localparam logic [15:0] CH2_CMD = 16'h0066;
	localparam int CH3_WIN_LSB = 5;
	localparam logic [4:0] SEL_DATA = 5'h00;
	localparam logic [4:0] SEL_STATUS = 5'h01;
	localparam logic [4:0] SEL_BIDIR = 5'h10;
	localparam logic [1:0] CHAN_1 = 2'h1;
	localparam logic [1:0] CHAN_2 = 2'h2;
	localparam logic [1:0] CHAN_3 = 2'h3;
	localparam logic [7:0] GATE_CMD = 8'hd1;
	localparam int GATE_DATA_BIT = 1;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [7:0] {
		L_IDLE = 8'h01, L_CTYPE = 8'h02, L_ADDR = 8'h04, L_WDATA = 8'h08,
		L_TAR1 = 8'h10, L_SYNC = 8'h20, L_RDATA = 8'h40, L_TAR2 = 8'h80
	} linkst_e;

	typedef struct packed {
		logic [1:0] chan;
		logic [4:0] sel;
		logic write;
		logic [7:0] wdata;
	} hostAcc_s;

	typedef struct packed {
		logic [7:0] ctl0;
		logic softRst;
		logic readZeroSeen;
		logic [15:0] ch3Addr;
		logic pdPrev;
		logic [7:0] rdata;
	} regState_s;

	typedef struct packed {
		linkst_e st;
		logic [1:0] nib;
		logic write;
		logic [15:0] addr;
		logic [7:0] wdata;
		logic [7:0] rdata;
		hostAcc_s acc;
		logic req;
		logic [3:0] ladOut;
		logic ladOeN;
		logic gateArm;
		logic gateState;
		logic gateOeN;
		logic sharedPin;
		logic [15:0] ch3Base;
		logic ch3EnPrev;
	} linkState_s;

	localparam regState_s REG_RESET = '{ctl0: CTL0_RESET,
		ch3Addr: CH3_ADDR_RESET, pdPrev: 1'b1, default: '0};
	localparam linkState_s LINK_RESET = '{st: L_IDLE, ladOut: LAD_TAR,
		ladOeN: 1'b1, gateState: 1'b1, gateOeN: 1'b1, default: '0};

endpackage

// ===== core/sync_two_flop.sv
`timescale 1ns/1ps
// Two-stage level synchroniser; stage one feeds stage two only
module sync_two_flop #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rstN,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	// Reset clears both stages so nothing stale leaks after reset
	always_ff @(posedge clk) begin
		if (!rstN) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule

// ===== core/host_addr_decode.sv
`timescale 1ns/1ps
// Maps a host I/O address onto a channel and a byte select
module host_addr_decode (
	input wire logic [15:0] addr,
	input wire logic [2:0] chEn,
	input wire logic [15:0] ch3Base,
	output logic hit,
	output logic [1:0] chan,
	output logic [4:0] sel
);
	import lpc_ctl_pkg::*;

	logic [4:0] off;

	// Only channel registers decode; the control block has no host path
	always_comb begin
		off = addr[4:0];
		hit = 1'b0;
		chan = CHAN_1;
		sel = SEL_DATA;
		if (chEn[0] && (addr == CH1_DATA || addr == CH1_CMD)) begin // R5 R13
			hit = 1'b1;
			sel = (addr == CH1_CMD) ? SEL_STATUS : SEL_DATA;
		end else if (chEn[1] && (addr == CH2_DATA || addr == CH2_CMD)) begin // R4
			hit = 1'b1;
			chan = CHAN_2;
			sel = (addr == CH2_CMD) ? SEL_STATUS : SEL_DATA;
		end else if (chEn[2] &&
			addr[15:CH3_WIN_LSB] == ch3Base[15:CH3_WIN_LSB]) begin // R3
			chan = CHAN_3;
			sel = off;
			hit = (off == SEL_DATA) || (off == SEL_STATUS) || (off >= SEL_BIDIR);
		end
	end
endmodule

// ===== core/lpc_channel_enable_control.sv
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ps
// Channel enable, fast gate and shutdown control with an I/O cycle target
module lpc_channel_enable_control (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata,
	input wire logic lclk,
	input wire logic lresetN,
	input wire logic lframeN,
	input wire logic [3:0] ladIn,
	output logic [3:0] ladOut,
	output logic ladOeN,
	input wire logic pdN,
	output logic hostReq,
	output lpc_ctl_pkg::hostAcc_s hostAcc,
	input wire logic [7:0] hostRdata,
	output logic gateA20Out,
	output logic gateA20OeN,
	output logic sharedPinIsGate
);
	import lpc_ctl_pkg::*;

	// ----------------------------------------------------------------
	// Processor side declarations
	// ----------------------------------------------------------------
	regState_s r_r;
	regState_s r_nxt;
	logic [2:0] mPins;
	logic lrstNM;
	logic pdNM;
	logic busyM;
	logic pdRise;
	logic hwShut;
	logic [7:0] linkStatus;

	// ----------------------------------------------------------------
	// Link side declarations
	// ----------------------------------------------------------------
	linkState_s l_r;
	linkState_s l_nxt;
	logic [1:0] lPins;
	logic lrstNL;
	logic pdNL;
	logic [5:0] lCfg;
	logic [2:0] chEnL;
	logic fgEnL;
	logic shutL;
	logic softL;
	logic linkOn;
	logic decHit;
	logic [1:0] decChan;
	logic [4:0] decSel;
	logic [15:0] fullAddr;
	logic [7:0] fullByte;

	// ----------------------------------------------------------------
	// Crossings into the processor clock
	// ----------------------------------------------------------------
	// Power-down travels inverted so a cleared stage reads as idle;
	// otherwise reset would fake a rising edge and a release event
	sync_two_flop #(.W(3)) u_sync_m (
		.clk(mclk),
		.rstN(nrst),
		.d({lresetN, ~pdN, l_r.st != L_IDLE}),
		.q(mPins)
	);

	assign lrstNM = mPins[2];
	assign pdNM = ~mPins[1];
	assign busyM = mPins[0];

	// Hardware shutdown needs both the enable and a low power-down level
	assign hwShut = r_r.ctl0[BIT_SDWN] & ~pdNM; // R8
	assign pdRise = pdNM & ~r_r.pdPrev;

	// Read-only view of link state and the software reset level
	always_comb begin
		linkStatus = 8'h00;
		linkStatus[LBIT_SOFTRST] = r_r.softRst;
		linkStatus[LBIT_LRST] = ~lrstNM;
		linkStatus[LBIT_PDLOW] = ~pdNM;
		linkStatus[LBIT_HWSHUT] = hwShut;
		linkStatus[LBIT_BUSY] = busyM;
	end

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	// Read data stands only in the cycle after the read strobe
	always_comb begin
		r_nxt = r_r;
		r_nxt.rdata = 8'h00;
		r_nxt.pdPrev = pdNM;
		if (regWr) begin
			case (regAddr)
				ADDR_CTL0: begin
					r_nxt.ctl0[BIT_CH3] = regWdata[BIT_CH3]; // R2
					r_nxt.ctl0[BIT_CH2] = regWdata[BIT_CH2]; // R2
					r_nxt.ctl0[BIT_CH1] = regWdata[BIT_CH1]; // R2
					r_nxt.ctl0[BIT_FGATE] = regWdata[BIT_FGATE];
					if (!regWdata[BIT_SDWN]) begin
						r_nxt.ctl0[BIT_SDWN] = 1'b0; // R10
					end else if (r_r.readZeroSeen) begin
						r_nxt.ctl0[BIT_SDWN] = 1'b1; // R9
					end
					r_nxt.readZeroSeen = 1'b0; // R9
				end
				ADDR_LINK: begin
					r_nxt.softRst = regWdata[LBIT_SOFTRST];
				end
				// Base is locked while channel 3 runs: the link copies it
				// only when the enable rises, so it must stay still
				ADDR_CH3_HI: begin
					if (!r_r.ctl0[BIT_CH3]) begin
						r_nxt.ch3Addr[15:8] = regWdata;
					end
				end
				ADDR_CH3_LO: begin
					if (!r_r.ctl0[BIT_CH3]) begin
						r_nxt.ch3Addr[7:0] = regWdata;
					end
				end
				default: begin
				end
			endcase
		end
		if (regRd) begin
			case (regAddr)
				ADDR_CTL0: begin
					r_nxt.rdata = r_r.ctl0;
					if (!r_r.ctl0[BIT_SDWN]) begin
						r_nxt.readZeroSeen = 1'b1; // R9
					end
				end
				ADDR_LINK: r_nxt.rdata = linkStatus;
				ADDR_CH3_HI: r_nxt.rdata = r_r.ch3Addr[15:8];
				ADDR_CH3_LO: r_nxt.rdata = r_r.ch3Addr[7:0];
				default: r_nxt.rdata = 8'h00;
			endcase
		end
		// Clearing events win over a software set in the same cycle
		if (!lrstNM || r_r.softRst || pdRise) begin
			r_nxt.ctl0[BIT_SDWN] = 1'b0; // R10
		end
	end

	// Processor side state register
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			r_r <= REG_RESET; // R2
		end else begin
			r_r <= r_nxt;
		end
	end

	assign regRdata = r_r.rdata;

	// ----------------------------------------------------------------
	// Crossings into the link clock
	// ----------------------------------------------------------------
	// Pin synchroniser runs without reset: it produces the link reset
	sync_two_flop #(.W(2)) u_sync_pins (
		.clk(lclk),
		.rstN(1'b1),
		.d({lresetN, pdN}),
		.q(lPins)
	);

	assign lrstNL = lPins[1];
	assign pdNL = lPins[0];

	sync_two_flop #(.W(6)) u_sync_cfg (
		.clk(lclk),
		.rstN(lrstNL),
		.d({r_r.ctl0[BIT_CH3], r_r.ctl0[BIT_CH2], r_r.ctl0[BIT_CH1],
			r_r.ctl0[BIT_FGATE], hwShut, r_r.softRst}),
		.q(lCfg)
	);

	assign chEnL = lCfg[5:3];
	assign fgEnL = lCfg[2];
	assign shutL = lCfg[1];
	assign softL = lCfg[0];

	// Any enabled channel brings the target up; power-down stops it
	assign linkOn = (|chEnL) & ~shutL & ~softL & pdNL; // R1 R8 R11

	assign fullAddr = {l_r.addr[11:0], ladIn};
	assign fullByte = {ladIn, l_r.wdata[7:4]};

	host_addr_decode u_decode (
		.addr(fullAddr),
		.chEn(chEnL),
		.ch3Base(l_r.ch3Base),
		.hit(decHit),
		.chan(decChan),
		.sel(decSel)
	);

	// ----------------------------------------------------------------
	// Link cycle engine
	// ----------------------------------------------------------------
	// Outputs are chosen for the coming cycle and then registered
	always_comb begin
		l_nxt = l_r;
		l_nxt.req = 1'b0;
		l_nxt.ladOeN = 1'b1;
		l_nxt.ladOut = LAD_TAR;
		l_nxt.ch3EnPrev = chEnL[2];
		l_nxt.sharedPin = fgEnL; // R6
		// Base word is quasi-static: sampled once as the enable rises
		if (chEnL[2] && !l_r.ch3EnPrev) begin
			l_nxt.ch3Base = r_r.ch3Addr; // R3
		end
		case (l_r.st)
			L_IDLE: begin
			end
			L_CTYPE: begin
				l_nxt.write = (ladIn == CT_IOWR);
				l_nxt.nib = 2'h0;
				if (ladIn == CT_IORD || ladIn == CT_IOWR) begin
					l_nxt.st = L_ADDR;
				end else begin
					l_nxt.st = L_IDLE;
				end
			end
			L_ADDR: begin
				l_nxt.addr = fullAddr;
				l_nxt.nib = l_r.nib + 2'h1;
				if (l_r.nib == NIB_LAST_ADDR) begin
					l_nxt.nib = 2'h0;
					l_nxt.acc.chan = decChan;
					l_nxt.acc.sel = decSel;
					l_nxt.acc.write = l_r.write;
					if (!decHit) begin
						l_nxt.st = L_IDLE; // R3 R4 R5
					end else if (l_r.write) begin
						l_nxt.st = L_WDATA;
					end else begin
						l_nxt.st = L_TAR1;
						l_nxt.req = 1'b1;
					end
				end
			end
			L_WDATA: begin
				l_nxt.wdata = fullByte;
				l_nxt.nib = l_r.nib + 2'h1;
				if (l_r.nib == NIB_LAST_BYTE) begin
					l_nxt.nib = 2'h0;
					l_nxt.st = L_TAR1;
					l_nxt.req = 1'b1;
					l_nxt.acc.wdata = fullByte;
					// Gate command then data byte, channel 1 only
					if (l_r.acc.chan == CHAN_1 && fgEnL) begin // R12
						if (l_r.acc.sel == SEL_STATUS) begin
							l_nxt.gateArm = (fullByte == GATE_CMD);
						end else if (l_r.gateArm) begin
							l_nxt.gateState = fullByte[GATE_DATA_BIT];
							l_nxt.gateArm = 1'b0;
						end
					end
				end
			end
			L_TAR1: begin
				l_nxt.nib = l_r.nib + 2'h1;
				if (l_r.nib == NIB_LAST_BYTE) begin
					l_nxt.nib = 2'h0;
					l_nxt.st = L_SYNC;
					l_nxt.rdata = hostRdata;
					l_nxt.ladOeN = 1'b0;
					l_nxt.ladOut = LAD_SYNC_READY;
				end
			end
			L_SYNC: begin
				l_nxt.ladOeN = 1'b0;
				if (l_r.write) begin
					l_nxt.st = L_TAR2;
				end else begin
					l_nxt.st = L_RDATA;
					l_nxt.ladOut = l_r.rdata[3:0];
				end
			end
			L_RDATA: begin
				l_nxt.ladOeN = 1'b0;
				if (l_r.nib == 2'h0) begin
					l_nxt.nib = 2'h1;
					l_nxt.ladOut = l_r.rdata[7:4];
				end else begin
					l_nxt.nib = 2'h0;
					l_nxt.st = L_TAR2;
				end
			end
			L_TAR2: begin
				l_nxt.st = L_IDLE;
			end
			default: begin
				l_nxt.st = L_IDLE;
			end
		endcase
		// Frame low starts a cycle anywhere, which also aborts one
		if (!lframeN) begin
			l_nxt.st = (ladIn == LAD_START) ? L_CTYPE : L_IDLE;
			l_nxt.nib = 2'h0;
			l_nxt.req = 1'b0;
			l_nxt.ladOeN = 1'b1;
		end
		if (!linkOn) begin
			l_nxt.st = L_IDLE; // R11
			l_nxt.req = 1'b0;
			l_nxt.ladOeN = 1'b1;
		end
		if (!fgEnL) begin
			l_nxt.gateState = 1'b1; // R6
			l_nxt.gateArm = 1'b0;
		end
		// Open-drain: enable low only while pulling the pin low
		l_nxt.gateOeN = ~(fgEnL & ~l_nxt.gateState); // R7
	end

	// Link side state register, reset by the synchronised link reset
	always_ff @(posedge lclk) begin
		if (!lrstNL) begin
			l_r <= LINK_RESET;
		end else begin
			l_r <= l_nxt;
		end
	end

	assign ladOut = l_r.ladOut;
	assign ladOeN = l_r.ladOeN;
	assign hostReq = l_r.req;
	assign hostAcc = l_r.acc;
	assign gateA20Out = 1'b0; // R7
	assign gateA20OeN = l_r.gateOeN;
	assign sharedPinIsGate = l_r.sharedPin;

endmodule

// ===== sim/lpc_ctl_monitor.sv
`timescale 1ns/1ps
// Watches the block's ports in both clock domains
module lpc_ctl_monitor (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic regRd,
	input wire logic [7:0] regRdata,
	input wire logic lclk,
	input wire logic lresetN,
	input wire logic [3:0] ladOut,
	input wire logic ladOeN,
	input wire logic pdN,
	input wire logic hostReq,
	input wire lpc_ctl_pkg::hostAcc_s hostAcc,
	input wire logic gateA20Out,
	input wire logic gateA20OeN,
	input wire logic sharedPinIsGate
);
	import lpc_ctl_pkg::*;
	// ------------------
	// Register port
	// ------------------
	a_rdata_idle: assert property (@(posedge mclk)
		disable iff (!nrst) !$past(regRd) |-> regRdata == 8'h00)
		else $error("read data outside its cycle");
	// ------------------
	// Link side
	// ------------------
	a_gate_low_only: assert property (@(posedge lclk)
		disable iff (!lresetN) $fell(gateA20OeN) |-> hostReq &&
		hostAcc.chan == CHAN_1 && hostAcc.write &&
		hostAcc.sel == SEL_DATA && !hostAcc.wdata[GATE_DATA_BIT])
		else $error("gate pulled without a channel 1 data write");
	a_gate_released: assert property (@(posedge lclk)
		disable iff (!lresetN) !sharedPinIsGate |-> gateA20OeN)
		else $error("gate pulls while pin released");
	a_req_single: assert property (@(posedge lclk)
		disable iff (!lresetN) hostReq |=> !hostReq)
		else $error("access pulse too long");
	// Host owns two turnaround cycles, then a ready sync follows
	a_req_turn: assert property (@(posedge lclk)
		disable iff (!lresetN) hostReq |-> ladOeN[*2] ##1
		(!ladOeN && ladOut == LAD_SYNC_READY))
		else $error("no turnaround then sync");
	a_lad_release: assert property (@(posedge lclk)
		disable iff (!lresetN)
		$fell(ladOeN) |-> ##[1:3] (ladOut == LAD_TAR ##1 ladOeN))
		else $error("link not released");
	a_pd_quiet: assert property (@(posedge lclk)
		disable iff (!lresetN) !pdN[*5] |-> !hostReq && ladOeN)
		else $error("active during power-down");
	a_bidir_ch3: assert property (@(posedge lclk)
		disable iff (!lresetN) hostReq && hostAcc.sel[4] |->
		hostAcc.chan == CHAN_3) else $error("bidir byte off channel 3");
	c_host_write: cover property (@(posedge lclk) hostReq && hostAcc.write);
	c_host_read: cover property (@(posedge lclk) hostReq && !hostAcc.write);
	c_gate_pull: cover property (@(posedge lclk) !gateA20OeN);
endmodule
bind lpc_channel_enable_control lpc_ctl_monitor mon (.mclk(mclk),
	.nrst(nrst), .regRd(regRd), .regRdata(regRdata), .lclk(lclk),
	.lresetN(lresetN), .ladOut(ladOut), .ladOeN(ladOeN), .pdN(pdN),
	.hostReq(hostReq), .hostAcc(hostAcc), .gateA20Out(gateA20Out),
	.gateA20OeN(gateA20OeN), .sharedPinIsGate(sharedPinIsGate));

// ===== sim/lpc_host_model.sv
`timescale 1ns/1ps
// Host controller end of the link: frames I/O cycles
module lpc_host_model (
	input wire logic lclk,
	input wire logic [3:0] ladOut,
	input wire logic ladOeN,
	output logic lframeN,
	output logic [3:0] ladIn
);
	import lpc_ctl_pkg::*;
	logic [3:0] drv = 4'hf;
	logic own = 1'b1;
	logic [3:0] junk = 4'h5;
	initial lframeN = 1'b1;
	// Released lines wander so a stale value never passes for data
	always @(posedge lclk) junk <= ~junk + 4'h3;
	assign ladIn = !ladOeN ? ladOut : (own ? drv : junk);
	// One I/O cycle; ok stays low when the target never answers
	task automatic io(input logic w, input logic [15:0] a,
		input logic [7:0] wd, output logic [7:0] rd, output logic ok);
		logic [3:0] seq[$];
		seq = {w ? CT_IOWR : CT_IORD, a[15:12], a[11:8], a[7:4], a[3:0]};
		if (w) seq = {seq, wd[3:0], wd[7:4]};
		rd = 8'h00;
		ok = 1'b0;
		@(posedge lclk);
		lframeN <= 1'b0;
		drv <= LAD_START;
		foreach (seq[i]) begin
			@(posedge lclk);
			lframeN <= 1'b1;
			drv <= seq[i];
		end
		@(posedge lclk);
		drv <= LAD_TAR;
		@(posedge lclk);
		own <= 1'b0;
		for (int n = 0; n < 8 && !ok; n++) begin
			@(posedge lclk);
			ok = ladOeN === 1'b0 && ladOut === LAD_SYNC_READY;
		end
		if (ok && !w) begin
			@(posedge lclk);
			rd[3:0] = ladOut;
			@(posedge lclk);
			rd[7:4] = ladOut;
		end
		@(posedge lclk);
		own <= 1'b1;
		drv <= LAD_TAR;
	endtask
endmodule

// ===== sim/testbench.sv
`timescale 1ns/1ps
module testbench;
	import lpc_ctl_pkg::*;
	logic mclk = 1'b0, lclk = 1'b0, nrst = 1'b0, lresetN = 1'b0;
	logic pdN = 1'b1, regWr = 1'b0, regRd = 1'b0, rdSeen = 1'b0;
	logic [7:0] regAddr = 8'h00, regWdata = 8'h00, hostRdata = 8'h00;
	logic [7:0] regRdata;
	logic [3:0] ladIn, ladOut;
	logic lframeN, ladOeN, hostReq, gateA20Out, gateA20OeN, sharedPinIsGate;
	hostAcc_s hostAcc;
	logic [15:0] base, hAddr;
	logic [4:0] hSel, bSel;
	logic [7:0] regQ[$];
	logic [15:0] accQ[$];
	int failures = 0;
	int total_checks = 0;
	// Clocks; 20 and 6 ns rising edges never coincide
	always #10 mclk = ~mclk;
	always #3 lclk = ~lclk;
	lpc_channel_enable_control uut (.mclk(mclk), .nrst(nrst),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .lclk(lclk), .lresetN(lresetN),
		.lframeN(lframeN), .ladIn(ladIn), .ladOut(ladOut), .ladOeN(ladOeN),
		.pdN(pdN), .hostReq(hostReq), .hostAcc(hostAcc),
		.hostRdata(hostRdata), .gateA20Out(gateA20Out),
		.gateA20OeN(gateA20OeN), .sharedPinIsGate(sharedPinIsGate));
	lpc_host_model host (.lclk(lclk), .ladOut(ladOut), .ladOeN(ladOeN),
		.lframeN(lframeN), .ladIn(ladIn));
	// --------------------
	// Checking
	// --------------------
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic complete_run();
		$display("checks=%0d failures=%0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Read data stand only in the cycle after the strobe
	always @(posedge mclk) begin
		if (rdSeen) chk({8'h00, regRdata}, {8'h00, regQ.pop_front()});
		rdSeen <= regRd;
	end
	// A pulse with no note pending compares against unknown and fails
	always @(posedge lclk) begin
		if (hostReq === 1'b1) chk(hostAcc.write ? 16'(hostAcc) :
			{hostAcc[15:8], 8'h00}, accQ.size() > 0 ? accQ.pop_front() : 'x);
	end
	// --------------------
	// Drivers
	// --------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk);
		regRd <= 1'b1;
		regAddr <= a;
		regQ.push_back(e);
		@(posedge mclk);
		regRd <= 1'b0;
	endtask
	task automatic hio(input logic w, input logic [15:0] a,
		input logic [7:0] d, input logic hit, input logic [1:0] ch,
		input logic [4:0] s);
		logic [7:0] got, rv;
		logic ok;
		rv = 8'($urandom);
		@(posedge mclk);
		hostRdata <= rv;
		if (hit) accQ.push_back({ch, s, w, w ? d : 8'h00});
		host.io(w, a, d, got, ok);
		chk({15'h0000, ok}, {15'h0000, hit});
		if (hit && !w) chk({8'h00, got}, {8'h00, rv});
	endtask
	task automatic sdSet(input logic [7:0] v);
		rd(ADDR_CTL0, v);
		wr(ADDR_CTL0, v | 8'h08);
		rd(ADDR_CTL0, v | 8'h08);
	endtask
	task automatic gate(input logic [2:0] e);
		repeat (4) @(posedge mclk);
		chk({13'h0000, sharedPinIsGate, gateA20OeN, gateA20Out}, {13'h0, e});
	endtask
	// Watchdog: a hang counts as a mismatch
	initial begin
		#400000;
		failures++;
		complete_run();
	end
	// --------------------
	// Main sequence
	// --------------------
	initial begin
		void'($urandom(32'hac4fdeca));
		repeat (2) @(posedge mclk);
		nrst <= 1'b1;
		lresetN <= 1'b1;
		wr(ADDR_CTL0, 8'h08);
		rd(ADDR_CTL0, CTL0_RESET);
		rd(8'h7f, 8'h00);
		base = {1'b1, 10'($urandom), 5'h00};
		wr(ADDR_CH3_HI, base[15:8]);
		wr(ADDR_CH3_LO, base[7:0]);
		rd(ADDR_CH3_HI, base[15:8]);
		$display("test reset done");
		// Each channel alone; only its own addresses may answer
		for (int c = 0; c < 4; c++) begin
			wr(ADDR_CTL0, c > 0 ? 8'(1 << (4 + c)) : 8'h00);
			rd(ADDR_CTL0, c > 0 ? 8'(1 << (4 + c)) : 8'h00);
			for (int n = 1; n < 4; n++) for (int k = 0; k < 2; k++) begin
				bSel = SEL_BIDIR | 5'($urandom % 16);
				hAddr = n == 1 ? (k ? CH1_CMD : CH1_DATA) : n == 2 ?
					(k ? CH2_CMD : CH2_DATA) : base + (k ? 16'h1 : 16'(bSel));
				hSel = n == 3 && !k ? bSel : (k ? SEL_STATUS : SEL_DATA);
				hio(1'($urandom), hAddr, 8'($urandom), n == c, 2'(n), hSel);
			end
		end
		wr(ADDR_CH3_HI, ~base[15:8]);
		rd(ADDR_CH3_HI, base[15:8]);
		$display("test channels done");
		wr(ADDR_CTL0, 8'h70);
		hio(1'b1, CH2_CMD, GATE_CMD, 1'b1, CHAN_2, SEL_STATUS);
		hio(1'b1, CH2_DATA, 8'h00, 1'b1, CHAN_2, SEL_DATA);
		gate(3'b110);
		hio(1'b1, CH1_CMD, GATE_CMD, 1'b1, CHAN_1, SEL_STATUS);
		hio(1'b1, CH1_DATA, 8'h00, 1'b1, CHAN_1, SEL_DATA);
		gate(3'b100);
		wr(ADDR_CTL0, 8'h60);
		gate(3'b010);
		wr(ADDR_CTL0, 8'h70);
		gate(3'b110);
		$display("test gate done");
		wr(ADDR_CTL0, 8'h20);
		sdSet(8'h20);
		pdN <= 1'b0;
		repeat (4) @(posedge mclk);
		rd(ADDR_LINK, 8'h0c);
		hio(1'b0, CH1_DATA, 8'h00, 1'b0, CHAN_1, SEL_DATA);
		pdN <= 1'b1;
		repeat (4) @(posedge mclk);
		rd(ADDR_CTL0, 8'h20);
		sdSet(8'h20);
		wr(ADDR_CTL0, 8'h20);
		rd(ADDR_CTL0, 8'h20);
		sdSet(8'h20);
		lresetN <= 1'b0;
		repeat (4) @(posedge mclk);
		lresetN <= 1'b1;
		repeat (4) @(posedge mclk);
		rd(ADDR_CTL0, 8'h20);
		sdSet(8'h20);
		wr(ADDR_LINK, 8'h01);
		repeat (4) @(posedge mclk);
		wr(ADDR_LINK, 8'h00);
		rd(ADDR_CTL0, 8'h20);
		hio(1'b0, CH1_DATA, 8'h00, 1'b1, CHAN_1, SEL_DATA);
		$display("test shutdown done");
		chk(16'(accQ.size() + regQ.size()), 16'h0000);
		complete_run();
	end
endmodule
